// ---- hw/pcic_lru.sv ----
// Four-entry recency stack of segment numbers.
// Assumes touches come from logic on the same clock.
`timescale 1ns/1ps
module pcic_lru (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic touch,
	input wire logic [1:0] seg,
	output logic [1:0] lru_seg,
	output logic [1:0] mru_seg
);
	import pcic_pkg::*;

	logic [1:0] stack_q [0:3];
	logic [3:0] at_or_above;

	// Marks the touched segment's position and every entry below it.
	always_comb begin
		at_or_above[0] = (stack_q[0] == seg);
		for (int i = 1; i < 4; i++) begin
			at_or_above[i] = at_or_above[i-1] | (stack_q[i] == seg);
		end
	end

	// Used segment goes on top, entries above its old slot shift down.
	// Entries below the old slot keep their place.
	generate
		for (genvar g = 0; g < 4; g++) begin : g_ent
			if (g == 0) begin : g_top
				always_ff @(posedge ref_clk or posedge sys_rst) begin
					if (sys_rst) begin
						stack_q[g] <= 2'(g);
					end else if (touch) begin
						stack_q[g] <= seg;
					end
				end
			end else begin : g_rest
				always_ff @(posedge ref_clk or posedge sys_rst) begin
					if (sys_rst) begin
						stack_q[g] <= 2'(g);
					end else if (touch && !at_or_above[g-1]) begin
						stack_q[g] <= stack_q[g-1];
					end
				end
			end
		end
	endgenerate

	// Bottom names the least recently used segment.
	assign lru_seg = stack_q[3];
	assign mru_seg = stack_q[0];

	a_lru_top: assert property (@(posedge ref_clk) disable iff (sys_rst)
		touch |=> mru_seg == $past(seg)) else $error("Touched not on top.");
	a_lru_perm: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(stack_q[0] ^ stack_q[1] ^ stack_q[2] ^ stack_q[3]) == 2'h0)
		else $error("Recency stack not a permutation.");
endmodule

// ---- hw/pcic_pkg.sv ----
// Package for the instruction pointer and instruction cache front end.
// Assumes a single processor clock; no software-visible registers.
package pcic_pkg;
	// Address field layout of a fetch address.
	localparam int PCIC_TAG_LSB = 9;
	localparam int PCIC_TAG_W = 23;
	localparam int PCIC_SUB_LSB = 6;
	localparam int PCIC_WRD_LSB = 4;
	localparam int PCIC_SEGS = 4;
	localparam int PCIC_SUBS = 8;
	localparam int PCIC_WORDS = 128;
	// Step of the pointer per fetched word, in bits.
	localparam logic [31:0] PCIC_STEP = 32'h0000_0010;
	// Reset value of the instruction pointer.
	localparam logic [31:0] PCIC_PTR_RST = 32'h0000_0000;
	// Flow change kinds offered by the execution unit.
	typedef enum logic [2:0] {
		PCIC_FLOW_NONE = 3'b000,
		PCIC_FLOW_ABS = 3'b001,
		PCIC_FLOW_REL8 = 3'b010,
		PCIC_FLOW_REL16 = 3'b011,
		PCIC_FLOW_IND = 3'b100
	} pcic_flow_e;
	// Cache controller states.
	typedef enum logic [1:0] {
		PCIC_ST_IDLE = 2'b00,
		PCIC_ST_LOOK = 2'b01,
		PCIC_ST_FILL = 2'b10,
		PCIC_ST_DONE = 2'b11
	} pcic_state_e;
endpackage

// ---- hw/pcic_top.sv ----
// Instruction pointer and 256-byte four-segment instruction cache.
// Assumes the execution unit and memory controller share ref_clk.
// Notes on behaviour
// - 32-bit bit pointer, low four bits zero
// - Each fetched word advances pointer by 16
// - Flow changes overwrite pointer, no advance
// - Absolute target loaded, low four bits cleared
// - Relative: sign-extend word displacement, shift, add
// - Indirect: register value, low four bits cleared
// - 128 sixteen-bit words, 256 bytes storage
// - Only pointer fetches use the cache
// - Four 32-word segments, eight four-word subsegments
// - Tag bits 9-31, subsegment 6-8, word 4-5
// - Hit needs tag match and present flag
// - Recency stack, used segment moves to top
// - Reset clears flags, stack 0 to 3
// - Hit returns cached word, promotes segment
// - Subsegment miss fills, promotes, sets flag
// - Segment miss replaces least recently used
// - Fetch waits for complete fill and flag
`timescale 1ns/1ps
module pcic_top (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic fetch_req,
	output logic fetch_ack,
	output logic [15:0] fetch_word,
	output logic [31:0] instruction_pointer,
	input wire pcic_pkg::pcic_flow_e flow_kind,
	input wire logic [31:0] flow_target,
	input wire logic [15:0] flow_disp,
	output logic fill_req,
	output logic [31:0] fill_addr,
	input wire logic fill_word_valid,
	input wire logic [15:0] fill_word
);
	import pcic_pkg::*;

	logic [15:0] store_q [0:PCIC_WORDS-1];
	logic [PCIC_TAG_W-1:0] segment_tag_q [0:PCIC_SEGS-1];
	logic [PCIC_SUBS-1:0] present_q [0:PCIC_SEGS-1];
	pcic_state_e state_q;
	logic [1:0] seg_q;
	logic [1:0] fill_cnt_q;
	logic [31:0] ptr_q;
	logic [31:0] ptr_d;
	logic [31:0] rel_off;
	logic [PCIC_TAG_W-1:0] addr_tag;
	logic [2:0] addr_sub;
	logic [1:0] addr_wrd;
	logic [3:0] tag_hit;
	logic hit_any;
	logic [1:0] hit_seg;
	logic [1:0] lru_seg;
	logic touch;

	// Fields of the fetch address.
	assign addr_tag = ptr_q[31:PCIC_TAG_LSB];
	assign addr_sub = ptr_q[PCIC_TAG_LSB-1:PCIC_SUB_LSB];
	assign addr_wrd = ptr_q[PCIC_SUB_LSB-1:PCIC_WRD_LSB];

	// Tag compare against every segment.
	generate
		for (genvar g = 0; g < PCIC_SEGS; g++) begin : g_cmp
			assign tag_hit[g] = (segment_tag_q[g] == addr_tag);
		end
	endgenerate

	// Matching segment number, if any.
	always_comb begin
		hit_any = 1'b0;
		hit_seg = 2'h0;
		for (int i = 0; i < PCIC_SEGS; i++) begin
			if (tag_hit[i] && !hit_any) begin
				hit_any = 1'b1;
				hit_seg = 2'(i);
			end
		end
	end

	// Relative offset: sign-extended words shifted to bit units.
	always_comb begin
		if (flow_kind == PCIC_FLOW_REL8) begin
			rel_off = {{20{flow_disp[7]}}, flow_disp[7:0], 4'h0};
		end else begin
			rel_off = {{12{flow_disp[15]}}, flow_disp, 4'h0};
		end
	end

	// Next pointer value for each kind of flow change.
	always_comb begin
		case (flow_kind)
			PCIC_FLOW_ABS: ptr_d = {flow_target[31:4], 4'h0};
			PCIC_FLOW_REL8, PCIC_FLOW_REL16: ptr_d = ptr_q + rel_off;
			PCIC_FLOW_IND: ptr_d = {flow_target[31:4], 4'h0};
			default: ptr_d = ptr_q;
		endcase
	end

	// Pointer register; a flow change overrides the sequential step.
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ptr_q <= PCIC_PTR_RST;
		end else if (flow_kind != PCIC_FLOW_NONE) begin
			ptr_q <= {ptr_d[31:4], 4'h0};
		end else if (fetch_ack) begin
			ptr_q <= ptr_q + PCIC_STEP;
		end
	end
	assign instruction_pointer = {ptr_q[31:4], 4'h0};

	// Fetch controller: look up, fill on miss, then answer from cache.
	// Data accesses never enter here; only pointer fetches do.
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_q <= PCIC_ST_IDLE;
			seg_q <= 2'h0;
			fill_cnt_q <= 2'h0;
		end else begin
			case (state_q)
				PCIC_ST_IDLE: begin
					if (fetch_req && flow_kind == PCIC_FLOW_NONE) begin
						state_q <= PCIC_ST_LOOK;
					end
				end
				PCIC_ST_LOOK: begin
					fill_cnt_q <= 2'h0;
					if (hit_any) begin
						seg_q <= hit_seg;
						state_q <= present_q[hit_seg][addr_sub] ?
							PCIC_ST_DONE : PCIC_ST_FILL;
					end else begin
						seg_q <= lru_seg;
						state_q <= PCIC_ST_FILL;
					end
				end
				PCIC_ST_FILL: begin
					if (fill_word_valid) begin
						fill_cnt_q <= fill_cnt_q + 2'h1;
						if (fill_cnt_q == 2'h3) begin
							state_q <= PCIC_ST_DONE;
						end
					end
				end
				PCIC_ST_DONE: state_q <= PCIC_ST_IDLE;
				default: state_q <= PCIC_ST_IDLE;
			endcase
		end
	end

	// Tags and present flags; segment miss clears the victim's flags.
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < PCIC_SEGS; i++) begin
				present_q[i] <= 8'h00;
				segment_tag_q[i] <= 23'h00_0000;
			end
		end else if (state_q == PCIC_ST_LOOK && !hit_any) begin
			present_q[lru_seg] <= 8'h00;
			segment_tag_q[lru_seg] <= addr_tag;
		end else if (state_q == PCIC_ST_FILL && fill_word_valid &&
			fill_cnt_q == 2'h3) begin
			present_q[seg_q][addr_sub] <= 1'b1;
		end
	end

	// Fill words land in ascending order within the subsegment.
	always_ff @(posedge ref_clk) begin
		if (state_q == PCIC_ST_FILL && fill_word_valid) begin
			store_q[{seg_q, addr_sub, fill_cnt_q}] <= fill_word;
		end
	end

	// Word is always read from the cache storage.
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			fetch_word <= 16'h0000;
		end else if (state_q == PCIC_ST_DONE) begin
			fetch_word <= store_q[{seg_q, addr_sub, addr_wrd}];
		end
	end

	// Answer pulse in the same cycle as the word that is read.
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			fetch_ack <= 1'b0;
		end else begin
			fetch_ack <= (state_q == PCIC_ST_DONE);
		end
	end

	// Fill request stands through the whole fill.
	assign fill_req = (state_q == PCIC_ST_FILL);
	assign fill_addr = {ptr_q[31:PCIC_SUB_LSB], 6'h00};

	// Promote the used segment once it is certain to hold the word.
	assign touch = (state_q == PCIC_ST_DONE);

	pcic_lru u_lru (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.touch(touch),
		.seg(seg_q),
		.lru_seg(lru_seg),
		.mru_seg()
	);


	// The visible pointer never leaves a word boundary.
	a_ptr_align: assert property (@(posedge ref_clk) disable iff (sys_rst)
		instruction_pointer[3:0] == 4'h0) else $error("Pointer unaligned.");

	// An answered fetch moves the pointer to the next word.
	a_ptr_step: assert property (@(posedge ref_clk) disable iff (sys_rst)
		fetch_ack && flow_kind == PCIC_FLOW_NONE |=>
		ptr_q == $past(ptr_q) + 32'h0000_0010) else $error("No step.");

	// Without a fetch answer or flow change the pointer holds.
	a_ptr_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
		flow_kind == PCIC_FLOW_NONE && !fetch_ack |=> ptr_q == $past(ptr_q))
		else $error("Pointer moved on its own.");

	// A flow change loads its target instead of stepping.
	a_ptr_flow: assert property (@(posedge ref_clk) disable iff (sys_rst)
		flow_kind != PCIC_FLOW_NONE |=> ptr_q == $past({ptr_d[31:4], 4'h0}))
		else $error("Flow change not loaded.");

	// Absolute target loaded with its low four bits cleared.
	a_abs_load: assert property (@(posedge ref_clk) disable iff (sys_rst)
		flow_kind == PCIC_FLOW_ABS |=> ptr_q == {$past(flow_target[31:4]), 4'h0})
		else $error("Absolute load wrong.");

	// Short displacement is sign-extended and scaled to bits.
	a_rel8_add: assert property (@(posedge ref_clk) disable iff (sys_rst)
		flow_kind == PCIC_FLOW_REL8 |=> ptr_q == $past(ptr_q) +
		{{20{$past(flow_disp[7])}}, $past(flow_disp[7:0]), 4'h0})
		else $error("Relative add wrong.");

	// Long displacement is sign-extended and scaled to bits.
	a_rel16_add: assert property (@(posedge ref_clk) disable iff (sys_rst)
		flow_kind == PCIC_FLOW_REL16 |=> ptr_q == $past(ptr_q) +
		{{12{$past(flow_disp[15])}}, $past(flow_disp), 4'h0})
		else $error("Long relative add wrong.");

	// Register value loaded with its low four bits cleared.
	a_ind_load: assert property (@(posedge ref_clk) disable iff (sys_rst)
		flow_kind == PCIC_FLOW_IND |=> ptr_q == {$past(flow_target[31:4]), 4'h0})
		else $error("Indirect load wrong.");

	// A present word is answered in the short cycle, no fill.
	a_hit_fast: assert property (@(posedge ref_clk) disable iff (sys_rst)
		state_q == PCIC_ST_LOOK && hit_any && present_q[hit_seg][addr_sub]
		|=> state_q == PCIC_ST_DONE ##1 fetch_ack)
		else $error("Hit not short.");

	// A hit never asks the memory for anything.
	a_hit_no_fill: assert property (@(posedge ref_clk) disable iff (sys_rst)
		state_q == PCIC_ST_LOOK && hit_any && present_q[hit_seg][addr_sub]
		|=> !fill_req) else $error("Fill on a hit.");

	// The answer strobe lasts a single cycle.
	a_ack_pulse: assert property (@(posedge ref_clk) disable iff (sys_rst)
		fetch_ack |=> !fetch_ack) else $error("Answer too long.");

	// The answering state always returns to idle.
	a_done_idle: assert property (@(posedge ref_clk) disable iff (sys_rst)
		state_q == PCIC_ST_DONE |=> state_q == PCIC_ST_IDLE)
		else $error("Answer state stuck.");

	// Idle never requests memory; only fetches can start a fill.
	a_idle_no_fill: assert property (@(posedge ref_clk) disable iff (sys_rst)
		state_q == PCIC_ST_IDLE |-> !fill_req)
		else $error("Fill while idle.");

	// A tag match selects the matching segment.
	a_hit_seg: assert property (@(posedge ref_clk) disable iff (sys_rst)
		state_q == PCIC_ST_LOOK && hit_any |=> seg_q == $past(hit_seg))
		else $error("Wrong segment chosen.");

	// A subsegment miss keeps the other flags of its segment.
	a_sub_keep: assert property (@(posedge ref_clk) disable iff (sys_rst)
		state_q == PCIC_ST_LOOK && hit_any |=>
		present_q[seg_q] == $past(present_q[hit_seg]))
		else $error("Flags lost on hit.");

	// A segment miss clears the victim's flags and starts a fill.
	a_miss_fill: assert property (@(posedge ref_clk) disable iff (sys_rst)
		state_q == PCIC_ST_LOOK && !hit_any |=> fill_req &&
		present_q[seg_q] == 8'h00) else $error("Segment miss wrong.");

	// The victim is the least recently used segment.
	a_victim_lru: assert property (@(posedge ref_clk) disable iff (sys_rst)
		state_q == PCIC_ST_LOOK && !hit_any |=> seg_q == $past(lru_seg))
		else $error("Victim not least recent.");

	// The victim takes the tag of the requested address.
	a_victim_tag: assert property (@(posedge ref_clk) disable iff (sys_rst)
		state_q == PCIC_ST_LOOK && !hit_any && flow_kind == PCIC_FLOW_NONE
		|=> segment_tag_q[seg_q] == addr_tag)
		else $error("Victim tag wrong.");

	// Each fill starts counting from the first word.
	a_fill_start: assert property (@(posedge ref_clk) disable iff (sys_rst)
		state_q == PCIC_ST_LOOK |=> fill_cnt_q == 2'h0)
		else $error("Fill count not cleared.");

	// The fill goes on until its fourth word is taken.
	a_fill_wait: assert property (@(posedge ref_clk) disable iff (sys_rst)
		state_q == PCIC_ST_FILL && !(fill_word_valid && fill_cnt_q == 2'h3)
		|=> state_q == PCIC_ST_FILL) else $error("Fill cut short.");

	// The fourth word sets the flag before the word is read.
	a_fill_flag: assert property (@(posedge ref_clk) disable iff (sys_rst)
		state_q == PCIC_ST_FILL && fill_word_valid && fill_cnt_q == 2'h3
		|=> state_q == PCIC_ST_DONE && present_q[seg_q][addr_sub])
		else $error("Flag not set after fill.");

	// No answer without the subsegment present.
	a_ack_flag: assert property (@(posedge ref_clk) disable iff (sys_rst)
		fetch_ack |-> present_q[seg_q][addr_sub])
		else $error("Answer without flag.");

	// Main scenarios: hit, both misses, replacement and relative flow.
	c_hit: cover property (@(posedge ref_clk)
		state_q == PCIC_ST_LOOK && hit_any && present_q[hit_seg][addr_sub]);
	c_sub_miss: cover property (@(posedge ref_clk)
		state_q == PCIC_ST_LOOK && hit_any && !present_q[hit_seg][addr_sub]);
	c_seg_miss: cover property (@(posedge ref_clk)
		state_q == PCIC_ST_LOOK && !hit_any);
	c_evict: cover property (@(posedge ref_clk)
		state_q == PCIC_ST_LOOK && !hit_any && present_q[lru_seg] != 8'h00);
	c_rel: cover property (@(posedge ref_clk) flow_kind == PCIC_FLOW_REL16);
endmodule

// ---- testbench/pcic_mem_model.sv ----
// Memory controller model that answers subsegment fills of the cache.
// Assumes fill_req and fill_addr hold steady for the length of a fill.
`timescale 1ns/1ps
module pcic_mem_model (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic fill_req,
	input wire logic [31:0] fill_addr,
	input wire logic slow,
	output logic fill_word_valid,
	output logic [15:0] fill_word
);
	logic [2:0] cnt_q;
	logic gap_q;

	// Memory contents are a fixed function of the word address.
	function automatic logic [15:0] word_at(input logic [31:0] a);
		return a[19:4] ^ 16'hc3a5;
	endfunction

	// Sends four words lowest address first; slow adds an idle cycle after each word.
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_q <= 3'h0;
			gap_q <= 1'h0;
			fill_word_valid <= 1'h0;
			fill_word <= 16'h0000;
		end else if (fill_req && cnt_q < 3'h4 && !(slow && !gap_q)) begin
			fill_word_valid <= 1'h1;
			fill_word <= word_at(fill_addr + {25'h0, cnt_q, 4'h0});
			cnt_q <= cnt_q + 3'h1;
			gap_q <= 1'h0;
		end else begin
			fill_word_valid <= 1'h0;
			fill_word <= ~fill_word; // Stale data flips every idle cycle.
			gap_q <= 1'h1;
			if (!fill_req) begin
				cnt_q <= 3'h0;
			end
		end
	end
endmodule

// ---- testbench/pcic_top_bench.sv ----
// Self-checking bench for the instruction pointer and cache front end.
// Assumes pcic_mem_model stands in for the memory controller.
`timescale 1ns/1ps
module pcic_top_bench;
	import pcic_pkg::*;
	logic ref_clk = 1'b0;
	logic sys_rst, fetch_req, fetch_ack, fill_req, fill_word_valid, slow;
	logic [15:0] fetch_word, flow_disp, fill_word;
	logic [31:0] instruction_pointer, flow_target, fill_addr, ptr_exp, r;
	logic [31:0] seed = 32'ha96a_daeb;
	logic [31:0] tgt [9] = '{32'h0000_2007, 32'h0000_400f, 32'h0000_6000,
		32'h0000_1201, 32'h0000_8000, 32'h0000_2000, 32'h0000_600c,
		32'h0000_4000, 32'h0000_1213};
	logic [8:0] miss_v = 9'h1b7;
	pcic_flow_e flow_kind;
	logic [47:0] exp_q [$];
	int mismatches = 0;
	int n_tests = 0;

	pcic_top pcic_top_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.fetch_req(fetch_req), .fetch_ack(fetch_ack),
		.fetch_word(fetch_word), .instruction_pointer(instruction_pointer),
		.flow_kind(flow_kind), .flow_target(flow_target),
		.flow_disp(flow_disp), .fill_req(fill_req), .fill_addr(fill_addr),
		.fill_word_valid(fill_word_valid), .fill_word(fill_word));
	pcic_mem_model pcic_mem_model_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.fill_req(fill_req), .fill_addr(fill_addr), .slow(slow),
		.fill_word_valid(fill_word_valid), .fill_word(fill_word));

	// Clock of 40 ns period.
	always #20 ref_clk = ~ref_clk;

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic check(input logic [47:0] seen, input logic [47:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict();
		if (mismatches == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Applies one flow change and checks the loaded pointer.
	task automatic flow(input pcic_flow_e k, input logic [31:0] t,
		input logic [15:0] d);
		flow_kind = k;
		flow_target = t;
		flow_disp = d;
		case (k)
			PCIC_FLOW_ABS, PCIC_FLOW_IND: ptr_exp = {t[31:4], 4'h0};
			PCIC_FLOW_REL8: ptr_exp += {{20{d[7]}}, d[7:0], 4'h0};
			PCIC_FLOW_REL16: ptr_exp += {{12{d[15]}}, d, 4'h0};
			default: ;
		endcase
		@(posedge ref_clk);
		#2 flow_kind = PCIC_FLOW_NONE;
		check(instruction_pointer, ptr_exp);
	endtask

	// Fetches one word; miss_exp 2 means the cache outcome is not known.
	task automatic fetch(input logic [1:0] miss_exp);
		int n;
		int s;
		n = 0;
		s = 0;
		exp_q.push_back({ptr_exp, pcic_mem_model_i.word_at(ptr_exp)});
		fetch_req = 1'b1;
		do begin
			@(posedge ref_clk);
			#1 n++;
			s += int'(fill_word_valid === 1'b1);
		end while (fetch_ack !== 1'b1 && n < 200);
		#1 fetch_req = 1'b0;
		if (miss_exp != 2'd2) check(s, miss_exp[0] ? 4 : 0);
		if (miss_exp == 2'd0) check(n, 3);
		ptr_exp += 32'h0000_0010;
		@(posedge ref_clk);
		#2 check(instruction_pointer, ptr_exp);
	endtask

	// Compares every answered word and its address with the oldest note.
	always @(posedge ref_clk) begin
		if (fetch_ack === 1'b1) begin
			if (exp_q.size() == 0) check(48'h0, 48'h1);
			else check({instruction_pointer, fetch_word}, exp_q.pop_front());
		end
	end

	// Cuts a hang short.
	initial begin
		#400000 mismatches++;
		print_verdict();
	end

	// Main sequence: fills, hits, replacement order, then random flow.
	initial begin
		sys_rst = 1'b1;
		fetch_req = 1'b0;
		flow_kind = PCIC_FLOW_NONE;
		flow_target = 32'h0000_0000;
		flow_disp = 16'h0000;
		slow = 1'b0;
		ptr_exp = 32'h0000_0000;
		repeat (10) @(posedge ref_clk);
		#2 sys_rst = 1'b0;
		check(instruction_pointer, 32'h0000_0000);
		flow(PCIC_FLOW_ABS, 32'h0000_1237, 16'h0000);
		fetch(2'd1);
		fetch(2'd1);
		flow(PCIC_FLOW_REL8, 32'h0000_0000, 16'hff_fb);
		repeat (5) fetch(2'd0);
		for (int i = 0; i < 9; i++) begin
			slow = i[1];
			flow(i[0] ? PCIC_FLOW_IND : PCIC_FLOW_ABS, tgt[i], 16'h0000);
			fetch({1'b0, miss_v[i]});
		end
		flow(PCIC_FLOW_REL16, 32'h0000_0000, 16'h8000);
		fetch(2'd2);
		repeat (12) begin
			r = xs();
			slow = r[5];
			flow(pcic_flow_e'(3'({1'b0, r[1:0]} + 3'h1)), r, r[31:16]);
			fetch(2'd2);
		end
		repeat (4) @(posedge ref_clk);
		print_verdict();
	end
endmodule
